// *** hdl/pfdiv_pkg.sv ***
// Package for the programmable frequency divider: register map, fields, bus carriers.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register bus.
package pfdiv_pkg;

    // ----------------------------------------------------------------
    // Register map (printed offsets are not multiples of four: indices)
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_INDEX      = 8'h2E;
    localparam logic [7:0]  VALUE_INDEX     = 8'h2F;
    localparam logic [11:0] CTRL_ADDR       = 12'(CTRL_INDEX * 4);
    localparam logic [11:0] VALUE_ADDR      = 12'(VALUE_INDEX * 4);
    localparam int          ADDR_W          = 12;

    // ----------------------------------------------------------------
    // Control fields and reset values
    // ----------------------------------------------------------------
    localparam int          EN_BIT          = 4;
    localparam int          PRESC_LO_BIT    = 5;
    localparam int          PRESC_HI_BIT    = 6;
    localparam int          SRC_BIT         = 7;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  VALUE_RESET     = 8'h00;
    localparam logic [7:0]  CTRL_WMASK      = 8'hF0;

    // ----------------------------------------------------------------
    // Clock sources as enables of the 10 MHz clock
    // ----------------------------------------------------------------
    localparam int          REF_CLK_HZ      = 10000000;
    localparam int          FAST_SRC_HZ     = 3580000 / 4;
    localparam int          SLOW_SRC_HZ     = 32768;
    localparam logic [31:0] FAST_INC        = 32'((64'(FAST_SRC_HZ) << 32) / REF_CLK_HZ);
    localparam logic [31:0] SLOW_INC        = 32'((64'(SLOW_SRC_HZ) << 32) / REF_CLK_HZ);

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } pfdiv_wr_type;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } pfdiv_rd_type;

    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } pfdiv_wstate_type;

endpackage

// *** hdl/pfdiv_top.sv ***
// Programmable frequency divider with AXI4-Lite register slave and tone output.
// Assumes one clock ref_clk at 10 MHz and synchronous active-high reset.
// Summary of operation
// - Enable bit drives tone; disabled holds low
// - Control bits 6:5 prescale by 1/2/4/8
// - Bit 7 picks fast/4 or 32768 source
// - Counter terminal value from divider register
// - Divider register writes ignored while disabled
// - Disabled divider clears divider register
// - Tone equals prescaled rate over 2(N+1)
// - Control bits 3:0 read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
module pfdiv_top
    import pfdiv_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       tone_output_pin
);
    import pfdiv_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]        divider_control;
    logic [7:0]        divider_value;
    logic              aw_held;
    logic              w_held;
    pfdiv_wr_type      wr;
    pfdiv_rd_type      rd;
    pfdiv_wstate_type  wstate;
    logic              divider_enable;
    logic              do_write;

    assign divider_enable = divider_control[EN_BIT];
    assign do_write       = (wstate == WR_IDLE) && aw_held && w_held;

    // Address and data are captured independently, in either order
    assign s_axi_awready = (wstate == WR_IDLE) && !aw_held;
    assign s_axi_wready  = (wstate == WR_IDLE) && !w_held;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr      <= '0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr.data <= s_axi_wdata;
                wr.strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wstate      <= WR_IDLE;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wstate)
                WR_IDLE: begin
                    if (do_write) begin
                        wstate      <= WR_RESP;
                        s_axi_bresp <= (wr.addr == CTRL_ADDR || wr.addr == VALUE_ADDR)
                                       ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wstate <= WR_IDLE;
                    end
                end
                default: wstate <= WR_IDLE;
            endcase
        end
    end
    assign s_axi_bvalid = (wstate == WR_RESP);

    // ----------------------------------------------------------------
    // Control and divider value registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            divider_control <= CTRL_RESET;
        end else if (do_write && wr.addr == CTRL_ADDR && wr.strb[0]) begin
            divider_control <= wr.data[7:0] & CTRL_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            divider_value <= VALUE_RESET;
        end else if (!divider_enable) begin
            divider_value <= VALUE_RESET;
        end else if (do_write && wr.addr == VALUE_ADDR && wr.strb[0]) begin
            divider_value <= wr.data[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Read channel: one cycle after the address is taken
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rdata   = rd.data;
    assign s_axi_rresp   = rd.resp;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            rd           <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == CTRL_ADDR) begin
                rd <= '{data: {24'h000000, divider_control & CTRL_WMASK},
                        resp: RESP_OKAY};
            end else if (s_axi_araddr == VALUE_ADDR) begin
                rd <= '{data: {24'h000000, divider_value}, resp: RESP_OKAY};
            end else begin
                rd <= '{data: 32'h00000000, resp: RESP_SLVERR};
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Source clock as a phase accumulator enable
    // ----------------------------------------------------------------
    // Both sources are slower than ref_clk, so each becomes a one-cycle tick;
    // jitter of one ref_clk period is the price of staying in one domain.
    logic [31:0] phase;
    logic [32:0] next_phase;
    logic        src_tick;

    assign next_phase = {1'b0, phase}
                      + {1'b0, (divider_control[SRC_BIT] ? FAST_INC : SLOW_INC)};
    assign src_tick   = next_phase[32];

    always_ff @(posedge ref_clk) begin
        if (rst || !divider_enable) begin
            phase <= 32'h00000000;
        end else begin
            phase <= next_phase[31:0];
        end
    end

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    logic [2:0] presc_count;
    logic       presc_tick;
    logic [1:0] presc_sel;

    assign presc_sel = {divider_control[PRESC_HI_BIT], divider_control[PRESC_LO_BIT]};

    always_comb begin
        case (presc_sel)
            2'h0:    presc_tick = src_tick;
            2'h1:    presc_tick = src_tick && (presc_count[0] == 1'b1);
            2'h2:    presc_tick = src_tick && (presc_count[1:0] == 2'h3);
            default: presc_tick = src_tick && (presc_count == 3'h7);
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !divider_enable) begin
            presc_count <= 3'h0;
        end else if (src_tick) begin
            presc_count <= presc_count + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // General counter and tone
    // ----------------------------------------------------------------
    logic [7:0] gen_count;
    logic       tone;

    always_ff @(posedge ref_clk) begin
        if (rst || !divider_enable) begin
            gen_count <= 8'h00;
            tone      <= 1'b0;
        end else if (presc_tick) begin
            if (gen_count >= divider_value) begin
                gen_count <= 8'h00;
                tone      <= ~tone;
            end else begin
                gen_count <= gen_count + 8'h01;
            end
        end
    end

    assign tone_output_pin = tone & divider_enable;

endmodule // pfdiv_top
`default_nettype wire

// *** testbench/pfdiv_chk.sv ***
// Checker for the frequency divider: bus handshakes, read-back and tone gating.
// Assumes it is bound into pfdiv_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module pfdiv_chk
    import pfdiv_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              tone_output_pin
);
    // ----------------------------------------------------------------
    // Shadow of the enable bit, rebuilt from completed writes
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_byte;
    logic              en_seen;
    logic              b_q;
    always_ff @(posedge ref_clk) b_q <= s_axi_bvalid && !rst;
    always_ff @(posedge ref_clk) if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    always_ff @(posedge ref_clk) if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
    always_ff @(posedge ref_clk) if (s_axi_wvalid && s_axi_wready) wr_byte <= s_axi_wdata[7:0];
    // Shadow lags the register by one cycle, so the response cycle is excused
    always_ff @(posedge ref_clk)
        if (rst) en_seen <= 1'h0;
        else if (s_axi_bvalid && !b_q && wr_addr == CTRL_ADDR) en_seen <= wr_byte[EN_BIT];
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
    property p_tone_off; !en_seen && !s_axi_bvalid |-> !tone_output_pin; endproperty
    a_tone_off: assert property (p_tone_off) else $error("tone while disabled");
    property p_val_zero;
        s_axi_rvalid && rd_addr == VALUE_ADDR && !en_seen |-> s_axi_rdata == 32'h0;
    endproperty
    a_val_zero: assert property (p_val_zero) else $error("divider value kept");
    property p_ctrl_low;
        s_axi_rvalid && rd_addr == CTRL_ADDR |-> s_axi_rdata[3:0] == 4'h0;
    endproperty
    a_ctrl_low: assert property (p_ctrl_low) else $error("low control bits set");
    property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data above bit 7");
    property p_slverr;
        s_axi_rvalid && rd_addr != CTRL_ADDR && rd_addr != VALUE_ADDR |-> s_axi_rresp == RESP_SLVERR;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
    // Address and data taken together: register written and answer raised on the next edge, seen one edge later
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer missing");
    c_tone: cover property ($rose(tone_output_pin));
    c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_wr: cover property (s_axi_bvalid && en_seen);
endmodule // pfdiv_chk
bind pfdiv_top pfdiv_chk u_chk (.*);
`default_nettype wire

// *** testbench/pfdiv_top_tb.sv ***
// Self-checking bench for pfdiv_top: register access over AXI4-Lite and tone timing.
// Assumes the package constants and the checker bound in beside the design.
`timescale 1ns/10ps
`default_nettype none
module pfdiv_top_tb;
    import pfdiv_pkg::*;
    logic              ref_clk = 1'h0;
    logic              rst = 1'h1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic              s_axi_awvalid = 1'h0;
    logic              s_axi_wvalid = 1'h0;
    logic              s_axi_bready = 1'h0;
    logic              s_axi_arvalid = 1'h0;
    logic              s_axi_rready = 1'h0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid, tone_output_pin;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [31:0]       s_axi_rdata;
    int                fails = 0;
    int                comparisons = 0;
    int                cyc = 0;
    pfdiv_top DUT (.*);
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc++;
    // ----------------------------------------------------------------
    // Compare, bus and measurement tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Accumulator jitter moves each edge by a cycle, hence the slack
    task automatic chk_near(input int g, input int e);
        comparisons++;
        if (g < e - 3 || g > e + 3) begin
            fails++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One write (w high) or one read; read data are compared with d
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [1:0] e);
        logic got;
        got = 1'h0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!got) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if ((w && s_axi_bvalid === 1'h1) || (!w && s_axi_rvalid === 1'h1)) begin
                got = 1'h1;
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                if (!w) chk(s_axi_rdata, d);
                chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, e});
            end
        end
    endtask
    // First edge after a value change may be short, so it is skipped
    task automatic tone_per(input int exp);
        int t0;
        repeat (2) @(posedge tone_output_pin);
        t0 = cyc;
        @(negedge tone_output_pin);
        chk_near(cyc - t0, exp / 2);
        @(posedge tone_output_pin);
        chk_near(cyc - t0, exp);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        acc(1'h0, CTRL_ADDR, CTRL_RESET, RESP_OKAY);
        acc(1'h0, VALUE_ADDR, VALUE_RESET, RESP_OKAY);
        acc(1'h1, VALUE_ADDR, 32'h55, RESP_OKAY);
        acc(1'h0, VALUE_ADDR, 32'h0, RESP_OKAY);
        acc(1'h1, CTRL_ADDR, 32'hFF, RESP_OKAY);
        acc(1'h0, CTRL_ADDR, 32'hF0, RESP_OKAY);
        acc(1'h1, VALUE_ADDR, 32'hA7, RESP_OKAY);
        acc(1'h0, VALUE_ADDR, 32'hA7, RESP_OKAY);
        // A write with its low byte lane off must leave the register alone
        s_axi_wstrb <= 4'h0;
        acc(1'h1, VALUE_ADDR, 32'h3C, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        acc(1'h0, VALUE_ADDR, 32'hA7, RESP_OKAY);
        acc(1'h1, 12'h0C0, 32'h1, RESP_SLVERR);
        acc(1'h0, 12'h0C0, 32'h0, RESP_SLVERR);
        for (int k = 0; k < 5; k++) begin
            acc(1'h1, CTRL_ADDR, 32'h0, RESP_OKAY);
            chk({31'h0, tone_output_pin}, 32'h0);
            acc(1'h0, VALUE_ADDR, 32'h0, RESP_OKAY);
            acc(1'h1, CTRL_ADDR, k < 4 ? 32'h90 + 32'(k * 32) : 32'h10, RESP_OKAY);
            acc(1'h1, VALUE_ADDR, k < 4 ? 32'h2 : 32'h1, RESP_OKAY);
            tone_per(k < 4 ? 6 * (1 << k) * REF_CLK_HZ / FAST_SRC_HZ
                           : 4 * REF_CLK_HZ / SLOW_SRC_HZ);
        end
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end
endmodule // pfdiv_top_tb
`default_nettype wire
